// ---- design/mbt_address_map.sv ----
// Purpose: Modbus TCP server address decoding for the soft-starter module
// Assumes: Requests arrive parsed, one per cycle, synchronous to mclk
// Notes: Reset stands for a power cycle; map settings are caught after it
`timescale 1ns/10ps

// Operation
// - Direct mode: address is parameter number
// - Direct mode ignores word map selectors
// - Direct mode serves holding registers only
// - Mapped mode exchanges configured words plus the holding parameter area
// - Mapped holding: write, read, parameter areas
// - Mapped input registers show read words
// - Mapped coils are write word bits
// - Mapped discrete inputs are read word bits
// - Word order setting selects byte order
// - Compatibility mode applies after power cycle
// - Writes to read words are discarded
// - Unused addresses read as zero
// - Lost link gives offline alarm or fault
// - Offline alarm clears when cause ends
// - Module access failure gives access event
// - No module retry until power cycle
// - Native board wins, module disabled, event
// - Inactivity timer from first telegram, zero disables
module mbt_address_map import mbt_pkg::*; #(
  parameter int UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Settings
  input wire logic address_compat_mode,
  input wire logic word_order,
  input wire logic error_reaction_setting,
  input wire logic [9:0] tcp_inactivity_timeout,
  input wire logic [NUM_RD_WORDS*PNUM_W-1:0] first_word_map_selector,
  input wire logic [NUM_WR_WORDS*PNUM_W-1:0] last_word_map_selector,
  // Modbus request
  input wire logic req_valid,
  output logic req_ready,
  input wire mbt_op_t req_op,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  // Modbus response
  output logic rsp_valid,
  output logic rsp_exc,
  output logic [15:0] rsp_data,
  // Read-only drive values
  input wire logic [15:0] drive_access_code,
  input wire logic [15:0] starter_current,
  input wire logic [15:0] motor_current_percent,
  input wire logic [15:0] starter_status_word,
  // Writable drive values
  output logic [15:0] initial_start_voltage,
  output logic [15:0] maximum_start_time,
  output logic [15:0] fieldbus_control_word,
  // Health inputs
  input wire logic link_down,
  input wire logic module_read_fail,
  input wire logic module_hw_incompat,
  input wire logic native_board_fitted,
  // Events and status
  output logic offline_state,
  output logic offline_alarm,
  output logic offline_fault,
  output logic module_access_alarm,
  output logic module_access_fault,
  output logic module_enabled
);

  // ********************
  // Declarations
  // ********************
  mbt_cfg_t cfg_q, cfg_d; // Start-up and run state
  logic mode_q, mode_d; // Latched compatibility mode
  logic react_q, react_d; // Latched error reaction
  logic [9:0] tmo_q, tmo_d; // Latched timeout
  logic [NUM_RD_WORDS*PNUM_W-1:0] rd_map_q, rd_map_d; // Latched read map
  logic [NUM_WR_WORDS*PNUM_W-1:0] wr_map_q, wr_map_d; // Latched write map
  logic [15:0] param_mem [0:PARAM_COUNT-1]; // Writable parameter store
  logic take; // Request taken this cycle
  logic is_write; // Request writes
  logic is_bit; // Coil or discrete access
  logic dec_param, dec_rd, dec_wr, dec_exc; // Decoded target kind
  logic [15:0] dec_pn; // Direct parameter number
  logic [7:0] dec_word; // Word slot index
  logic [3:0] dec_bit; // Bit inside word
  logic [PNUM_W-1:0] rd_sel, wr_sel; // Selected parameters
  logic rd_hit, wr_hit; // Slot is in use
  logic [15:0] tgt_pn; // Final parameter number
  logic tgt_ok; // Target exists
  logic tgt_ro; // Target is read-only
  logic [15:0] cur_val; // Current target value
  logic [15:0] wr_val; // Host-order write data
  logic [15:0] new_val; // Value to store
  logic mem_we; // Store write enable
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_exc_q, rsp_exc_d;
  logic [15:0] rsp_data_q, rsp_data_d;
  logic [15:0] isv_q, isv_d, mst_q, mst_d, fcw_q, fcw_d; // Drive mirrors
  logic tmr_expired; // Inactivity limit hit
  logic off_cause; // Offline condition
  logic acc_cause; // Module access condition
  logic off_q, off_d, off_al_q, off_al_d, off_ft_q, off_ft_d;
  logic acc_al_q, acc_al_d, acc_ft_q, acc_ft_d;

  // ********************
  // Word map lookups
  // ********************
  mbt_word_map #(.N(NUM_RD_WORDS)) u_rd_map (
    .sel_vec(rd_map_q),
    .index(dec_word),
    .sel_out(rd_sel),
    .hit(rd_hit)
  );

  mbt_word_map #(.N(NUM_WR_WORDS)) u_wr_map (
    .sel_vec(wr_map_q),
    .index(dec_word),
    .sel_out(wr_sel),
    .hit(wr_hit)
  );

  // ********************
  // Inactivity timer
  // ********************
  mbt_idle_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .timeout_units(tmo_q),
    .kick(take),
    .expired(tmr_expired)
  );

  // ********************
  // Address decode
  // ********************
  assign req_ready = (cfg_q == CFG_RUN);
  assign take = req_valid && req_ready;
  assign is_write = (req_op == OP_WR_HOLD) || (req_op == OP_WR_COIL);
  assign is_bit = (req_op == OP_RD_COIL) || (req_op == OP_WR_COIL) || (req_op == OP_RD_DISC);

  // Sorts the address into parameter, read word or write word
  always_comb begin
    dec_param = 1'b0;
    dec_rd = 1'b0;
    dec_wr = 1'b0;
    dec_exc = 1'b0;
    dec_pn = req_addr;
    dec_word = req_addr[7:0];
    dec_bit = req_addr[3:0];
    if (mode_q == MODE_DIRECT) begin
      // Word slots unused here
      if ((req_op == OP_RD_HOLD) || (req_op == OP_WR_HOLD)) begin
        dec_param = 1'b1;
      end else begin
        dec_exc = 1'b1;
      end
    end else begin
      case (req_op)
        OP_RD_HOLD, OP_WR_HOLD: begin
          // Three holding areas
          if (req_addr <= HOLD_WR_HI) begin
            dec_wr = 1'b1;
          end else if ((req_addr >= HOLD_RD_LO) && (req_addr <= HOLD_RD_HI)) begin
            dec_rd = 1'b1;
          end else if (req_addr >= HOLD_PARAM_BASE) begin
            dec_param = 1'b1;
            dec_pn = req_addr - HOLD_PARAM_BASE + 16'h0001;
          end
        end
        OP_RD_INPUT: begin
          dec_rd = (req_addr <= INPUT_HI);
        end
        OP_RD_COIL, OP_WR_COIL: begin
          dec_wr = (req_addr <= BIT_HI);
          dec_word = req_addr[11:4];
        end
        OP_RD_DISC: begin
          dec_rd = (req_addr <= BIT_HI);
          dec_word = req_addr[11:4];
        end
        default: begin
          dec_exc = 1'b1;
        end
      endcase
    end
  end

  // ********************
  // Target resolution
  // ********************
  // Picks the parameter and its present value
  always_comb begin
    tgt_pn = dec_pn;
    if (dec_rd) begin
      tgt_pn = {5'h00, rd_sel};
    end else if (dec_wr) begin
      tgt_pn = {5'h00, wr_sel};
    end
    // Slots past the configured count are unused
    tgt_ok = (dec_param || (dec_rd && rd_hit) || (dec_wr && wr_hit)) && (tgt_pn < PARAM_COUNT);
    tgt_ro = 1'b0;
    cur_val = 16'h0000; // Unused addresses read zero
    if (tgt_ok) begin
      case (tgt_pn[PNUM_W-1:0])
        PAR_ACCESS_CODE: begin
          cur_val = drive_access_code;
          tgt_ro = 1'b1;
        end
        PAR_STARTER_CURRENT: begin
          cur_val = starter_current;
          tgt_ro = 1'b1;
        end
        PAR_MOTOR_CURRENT_PCT: begin
          cur_val = motor_current_percent;
          tgt_ro = 1'b1;
        end
        PAR_STATUS_WORD: begin
          cur_val = starter_status_word;
          tgt_ro = 1'b1;
        end
        default: begin
          cur_val = param_mem[tgt_pn[PNUM_W-1:0]];
        end
      endcase
    end
  end

  // ********************
  // Write path
  // ********************
  // Undoes the wire byte order on incoming words
  assign wr_val = (word_order == ORDER_MSB_FIRST) ? req_wdata : {req_wdata[7:0], req_wdata[15:8]};

  // Merges a coil bit or takes the whole word
  always_comb begin
    new_val = wr_val;
    if (is_bit) begin
      new_val = cur_val;
      new_val[dec_bit] = req_wdata[0];
    end
  end

  // Read words and read-only parameters never change
  assign mem_we = take && is_write && tgt_ok && !dec_rd && !tgt_ro && !dec_exc;

  // Parameter store
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      param_mem[tgt_pn[PNUM_W-1:0]] <= new_val;
    end
  end

  // ********************
  // Response and drive mirrors
  // ********************
  // Builds the answer and tracks written drive values
  always_comb begin
    rsp_valid_d = take;
    rsp_exc_d = rsp_exc_q;
    rsp_data_d = rsp_data_q;
    isv_d = isv_q;
    mst_d = mst_q;
    fcw_d = fcw_q;
    if (take) begin
      rsp_exc_d = dec_exc;
      if (dec_exc) begin
        rsp_data_d = 16'h0000;
      end else if (is_write) begin
        rsp_data_d = req_wdata; // Echo as received
      end else if (is_bit) begin
        rsp_data_d = {15'h0000, cur_val[dec_bit]};
      end else if (word_order == ORDER_MSB_FIRST) begin
        rsp_data_d = cur_val;
      end else begin
        rsp_data_d = {cur_val[7:0], cur_val[15:8]};
      end
    end
    if (mem_we && (tgt_pn[PNUM_W-1:0] == PAR_INIT_START_VOLT)) begin
      isv_d = new_val;
    end
    if (mem_we && (tgt_pn[PNUM_W-1:0] == PAR_MAX_START_TIME)) begin
      mst_d = new_val;
    end
    if (mem_we && (tgt_pn[PNUM_W-1:0] == PAR_FB_CONTROL)) begin
      fcw_d = new_val;
    end
  end

  // ********************
  // Configuration and events
  // ********************
  assign off_cause = (cfg_q == CFG_RUN) && (link_down || tmr_expired);
  assign acc_cause = module_read_fail || module_hw_incompat || native_board_fitted;

  // Latches map settings once and tracks event flags
  always_comb begin
    cfg_d = cfg_q;
    mode_d = mode_q;
    react_d = react_q;
    tmo_d = tmo_q;
    rd_map_d = rd_map_q;
    wr_map_d = wr_map_q;
    acc_al_d = acc_al_q;
    acc_ft_d = acc_ft_q;
    case (cfg_q)
      CFG_LOAD: begin
        // Settings other than word_order are taken only here, after power-up
        mode_d = address_compat_mode;
        react_d = error_reaction_setting;
        tmo_d = tcp_inactivity_timeout;
        rd_map_d = first_word_map_selector;
        wr_map_d = last_word_map_selector;
        cfg_d = acc_cause ? CFG_DISABLED : CFG_RUN;
      end
      CFG_RUN: begin
        if (acc_cause) begin
          cfg_d = CFG_DISABLED;
        end
      end
      CFG_DISABLED: begin
        cfg_d = CFG_DISABLED; // Held until power cycle
      end
      default: begin
        cfg_d = CFG_LOAD;
      end
    endcase
    if ((cfg_q != CFG_DISABLED) && acc_cause) begin
      acc_al_d = (react_q == REACT_ALARM) || (cfg_q == CFG_LOAD && !error_reaction_setting);
      acc_ft_d = !acc_al_d;
    end
    off_d = off_cause;
    off_al_d = off_cause && (react_q == REACT_ALARM);
    off_ft_d = off_ft_q || (off_cause && (react_q != REACT_ALARM));
  end

  // ********************
  // Registers
  // ********************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= CFG_LOAD;
      mode_q <= MODE_DIRECT;
      react_q <= REACT_ALARM;
      tmo_q <= '0;
      rd_map_q <= '0;
      wr_map_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_exc_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      isv_q <= PARAM_RESET;
      mst_q <= PARAM_RESET;
      fcw_q <= PARAM_RESET;
      off_q <= 1'b0;
      off_al_q <= 1'b0;
      off_ft_q <= 1'b0;
      acc_al_q <= 1'b0;
      acc_ft_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
      react_q <= react_d;
      tmo_q <= tmo_d;
      rd_map_q <= rd_map_d;
      wr_map_q <= wr_map_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_exc_q <= rsp_exc_d;
      rsp_data_q <= rsp_data_d;
      isv_q <= isv_d;
      mst_q <= mst_d;
      fcw_q <= fcw_d;
      off_q <= off_d;
      off_al_q <= off_al_d;
      off_ft_q <= off_ft_d;
      acc_al_q <= acc_al_d;
      acc_ft_q <= acc_ft_d;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign rsp_valid = rsp_valid_q;
  assign rsp_exc = rsp_exc_q;
  assign rsp_data = rsp_data_q;
  assign initial_start_voltage = isv_q;
  assign maximum_start_time = mst_q;
  assign fieldbus_control_word = fcw_q;
  assign offline_state = off_q;
  assign offline_alarm = off_al_q;
  assign offline_fault = off_ft_q;
  assign module_access_alarm = acc_al_q;
  assign module_access_fault = acc_ft_q;
  assign module_enabled = (cfg_q == CFG_RUN);

endmodule : mbt_address_map

// ---- design/mbt_pkg.sv ----
// Purpose: Shared constants and types of the Modbus TCP address map block
// Assumes: One 100 MHz clock; parameter numbers fit in 11 bits
// Notes: Addresses are Modbus register or bit addresses, not byte addresses
package mbt_pkg;

  // ********************
  // Widths and sizes
  // ********************
  localparam int PNUM_W = 11; // Parameter number width
  localparam int NUM_RD_WORDS = 8; // Mapped read word slots
  localparam int NUM_WR_WORDS = 8; // Mapped write word slots
  localparam logic [15:0] PARAM_COUNT = 16'h0424; // Parameters 0 to 1059

  // ********************
  // Mapped mode address windows
  // ********************
  localparam logic [15:0] HOLD_WR_HI = 16'h00FF; // Write words end
  localparam logic [15:0] HOLD_RD_LO = 16'h0100; // Read words start
  localparam logic [15:0] HOLD_RD_HI = 16'h01FF; // Read words end
  localparam logic [15:0] HOLD_PARAM_BASE = 16'h0210; // Parameter 1 lives here
  localparam logic [15:0] INPUT_HI = 16'h00FF; // Input registers end
  localparam logic [15:0] BIT_HI = 16'h0FFF; // Coils and inputs end

  // ********************
  // Drive parameter numbers
  // ********************
  localparam logic [10:0] PAR_ACCESS_CODE = 11'h000;
  localparam logic [10:0] PAR_STARTER_CURRENT = 11'h001;
  localparam logic [10:0] PAR_MOTOR_CURRENT_PCT = 11'h002;
  localparam logic [10:0] PAR_INIT_START_VOLT = 11'h065;
  localparam logic [10:0] PAR_MAX_START_TIME = 11'h066;
  localparam logic [10:0] PAR_STATUS_WORD = 11'h2A8;
  localparam logic [10:0] PAR_FB_CONTROL = 11'h2AE;

  // ********************
  // Setting encodings and reset values
  // ********************
  localparam logic MODE_DIRECT = 1'b0; // Parameter number is address
  localparam logic MODE_MAPPED = 1'b1; // Word windows plus offset area
  localparam logic ORDER_MSB_FIRST = 1'b0; // High byte sent first
  localparam logic REACT_ALARM = 1'b0; // Events reported as alarms
  localparam logic [15:0] PARAM_RESET = 16'h0000;

  // ********************
  // Timing
  // ********************
  localparam int CLK_MHZ = 100; // mclk rate
  localparam int TIMEOUT_UNIT_MS = 100;     // One step of the timeout setting
  localparam int TIMEOUT_UNIT_CYCLES = TIMEOUT_UNIT_MS * 1000 * CLK_MHZ;

  // ********************
  // Types
  // ********************
  typedef enum logic [2:0] {
    OP_RD_HOLD = 3'h0,
    OP_WR_HOLD = 3'h1,
    OP_RD_INPUT = 3'h2,
    OP_RD_COIL = 3'h3,
    OP_WR_COIL = 3'h4,
    OP_RD_DISC = 3'h5
  } mbt_op_t;

  typedef enum logic [1:0] {
    CFG_LOAD = 2'b00,
    CFG_RUN = 2'b01,
    CFG_DISABLED = 2'b10
  } mbt_cfg_t;

endpackage : mbt_pkg

// ---- design/mbt_word_map.sv ----
// Purpose: Look up one mapped word slot in a list of parameter selectors
// Assumes: The list is in use up to its first zero selector
// Notes: Purely combinational
`timescale 1ns/10ps

module mbt_word_map import mbt_pkg::*; #(
  parameter int N = 8
) (
  // Selector list
  input wire logic [N*PNUM_W-1:0] sel_vec,
  // Lookup
  input wire logic [7:0] index,
  output logic [PNUM_W-1:0] sel_out,
  output logic hit
);

  logic open_run; // Still inside the used part of the list

  // ********************
  // Slot lookup
  // ********************
  // Stops counting at the first zero selector
  always_comb begin
    open_run = 1'b1;
    sel_out = '0;
    hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (sel_vec[i*PNUM_W +: PNUM_W] == '0) begin
        open_run = 1'b0;
      end
      if (open_run && (index == 8'(i))) begin
        hit = 1'b1;
        sel_out = sel_vec[i*PNUM_W +: PNUM_W];
      end
    end
  end

endmodule : mbt_word_map

// ---- design/mbt_idle_timer.sv ----
// Purpose: Inactivity timer for the Modbus TCP link
// Assumes: kick pulses once for each valid telegram
// Notes: A timeout of zero keeps the timer idle
`timescale 1ns/10ps

module mbt_idle_timer import mbt_pkg::*; #(
  parameter int UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic [9:0] timeout_units,
  input wire logic kick,
  // Status
  output logic expired
);

  logic started_q, started_d; // First telegram seen
  logic [31:0] pre_q, pre_d; // Cycles inside one unit
  logic [9:0] units_q, units_d; // Whole units elapsed
  logic expired_q, expired_d; // Time limit reached

  // ********************
  // Next state
  // ********************
  always_comb begin
    started_d = started_q;
    pre_d = pre_q;
    units_d = units_q;
    expired_d = expired_q;
    if (kick) begin
      // Every telegram restarts the count
      started_d = 1'b1;
      pre_d = '0;
      units_d = '0;
      expired_d = 1'b0;
    end else if (started_q && (timeout_units != 10'h000) && !expired_q) begin
      if (pre_q == 32'(UNIT_CYCLES - 1)) begin
        pre_d = '0;
        units_d = units_q + 10'h001;
        if (units_d == timeout_units) begin
          expired_d = 1'b1;
        end
      end else begin
        pre_d = pre_q + 32'h00000001;
      end
    end
  end

  // ********************
  // Registers
  // ********************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      started_q <= 1'b0;
      pre_q <= '0;
      units_q <= '0;
      expired_q <= 1'b0;
    end else begin
      started_q <= started_d;
      pre_q <= pre_d;
      units_q <= units_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;

endmodule : mbt_idle_timer

// ---- sim/mbt_props.sv ----
// Purpose: Port assertions for the address map block
// Assumes: Settings held steady while out of reset
// Notes: Bound to every instance of the top module
`timescale 1ns/10ps
module mbt_props import mbt_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Request and response
  input wire logic req_valid,
  input wire logic req_ready,
  input wire mbt_op_t req_op,
  input wire logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_exc,
  input wire logic [15:0] rsp_data,
  // Health and events
  input wire logic link_down,
  input wire logic module_read_fail,
  input wire logic module_hw_incompat,
  input wire logic native_board_fitted,
  input wire logic offline_state,
  input wire logic offline_alarm,
  input wire logic offline_fault,
  input wire logic module_access_alarm,
  input wire logic module_access_fault,
  input wire logic module_enabled
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic take = req_valid && req_ready; // Request accepted
  wire logic acc = module_access_alarm || module_access_fault; // Access event
  rsp_after_take_a: assert property (take |=> rsp_valid)
    else $error("request not answered");
  rsp_has_cause_a: assert property (rsp_valid |-> $past(take))
    else $error("response without request");
  wr_echo_a: assert property (take && req_op == OP_WR_HOLD |=> rsp_data == $past(req_wdata))
    else $error("write not echoed");
  exc_zero_a: assert property (rsp_valid && rsp_exc |-> rsp_data == 16'h0)
    else $error("exception carries data");
  offline_hit_a: assert property ($past(link_down) && $past(module_enabled) |-> offline_state)
    else $error("link loss not seen");
  alarm_tied_a: assert property (offline_alarm && module_enabled |-> offline_state && !offline_fault)
    else $error("alarm without cause");
  fault_sticky_a: assert property (offline_fault |=> offline_fault)
    else $error("offline fault dropped");
  access_hold_a: assert property (acc |=> $stable({module_access_alarm, module_access_fault}))
    else $error("access event changed");
  access_shut_a: assert property (acc |-> !req_ready && !module_enabled)
    else $error("module used after access event");
  access_cause_a: assert property (module_enabled && (module_read_fail || module_hw_incompat
    || native_board_fitted) |=> acc && !module_enabled)
    else $error("access cause ignored");
  // Main scenarios reached
  cover property (take && req_op == OP_RD_COIL);
  cover property (rsp_valid && rsp_exc);
  cover property (offline_alarm);
  cover property (module_access_fault);
endmodule : mbt_props

bind mbt_address_map mbt_props u_props (.*);

// ---- sim/mbt_master.sv ----
// Purpose: Network master model issuing parsed requests
// Assumes: Requests change only at the falling edge
// Notes: Released address and data lines carry the inverse of the last value; the op is kept
`timescale 1ns/10ps
module mbt_master import mbt_pkg::*; (
  // Clock
  input wire logic mclk,
  // Request
  output logic req_valid,
  input wire logic req_ready,
  output mbt_op_t req_op,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  // Response
  input wire logic rsp_valid,
  input wire logic rsp_exc,
  input wire logic [15:0] rsp_data
);
  // Idle request lines
  initial begin
    req_valid = 1'b0;
    req_op = OP_RD_HOLD;
    req_addr = 16'h0;
    req_wdata = 16'h0;
  end
  // One request; ok low when not taken or not answered in time
  task automatic xfer(input mbt_op_t op, input logic [15:0] a, d,
      output logic [15:0] q, output logic e, output bit ok);
    ok = 1'b0;
    q = 16'h0;
    e = 1'b0;
    @(negedge mclk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge mclk);
      ok = req_ready;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    req_addr = ~a;
    req_wdata = ~d;
    for (int n = 0; n < 3 && ok && !rsp_valid; n++) @(negedge mclk);
    ok = ok && rsp_valid;
    q = rsp_data;
    e = rsp_exc;
  endtask : xfer
endmodule : mbt_master

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the address map block
// Assumes: Timer unit shortened to 10 cycles
// Notes: Each boot stands for a power cycle
`timescale 1ns/10ps
module testbench import mbt_pkg::*;;
  logic mclk, sys_rst, address_compat_mode, word_order, error_reaction_setting;
  logic [9:0] tcp_inactivity_timeout;
  logic [87:0] first_word_map_selector, last_word_map_selector;
  logic req_valid, req_ready, rsp_valid, rsp_exc;
  mbt_op_t req_op;
  logic [15:0] req_addr, req_wdata, rsp_data, drive_access_code, starter_current;
  logic [15:0] motor_current_percent, starter_status_word, initial_start_voltage;
  logic [15:0] maximum_start_time, fieldbus_control_word;
  logic link_down, module_read_fail, module_hw_incompat, native_board_fitted;
  logic offline_state, offline_alarm, offline_fault, module_access_alarm;
  logic module_access_fault, module_enabled;
  int fail_count = 0;
  int num_checks = 0;
  mbt_address_map #(.UNIT_CYCLES(10)) u_mbt_address_map (.*);
  mbt_master u_mbt_master (.mclk, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata,
    .rsp_valid, .rsp_exc, .rsp_data);
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] s, x);
    num_checks++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // Power cycle with new settings
  task automatic boot(input logic m, r, input logic [9:0] t);
    @(negedge mclk);
    sys_rst = 1'b1;
    address_compat_mode = m;
    error_reaction_setting = r;
    tcp_inactivity_timeout = t;
    {link_down, module_read_fail, module_hw_incompat, native_board_fitted} = 4'h0;
    cyc(12);
    sys_rst = 1'b0;
    cyc(2);
  endtask : boot
  // One request, judged on data and exception
  task automatic rw(input mbt_op_t op, input logic [15:0] a, d, x, input logic xe);
    logic [15:0] q;
    logic e;
    bit ok;
    u_mbt_master.xfer(op, a, d, q, e, ok);
    if (!ok) begin
      fail_count++;
      $display("BAD %0t no answer", $time);
      complete_run;
    end
    check(q, x);
    check(16'(e), 16'(xe));
  endtask : rw
  task automatic s_direct;
    boot(MODE_DIRECT, REACT_ALARM, 10'h0);
    rw(OP_RD_HOLD, 16'h0001, 16'h0, 16'h1234, 1'b0);
    rw(OP_RD_HOLD, 16'h02A8, 16'h0, 16'hA5C3, 1'b0);
    rw(OP_RD_HOLD, 16'h0000, 16'h0, 16'h0007, 1'b0);
    rw(OP_WR_HOLD, 16'h0065, 16'h0BCD, 16'h0BCD, 1'b0);
    check(initial_start_voltage, 16'h0BCD);
    rw(OP_RD_HOLD, 16'h0500, 16'h0, 16'h0, 1'b0);
    for (int i = 2; i <= 5; i++) rw(mbt_op_t'(i), 16'h0001, 16'h0, 16'h0, 1'b1);
    word_order = 1'b1;
    rw(OP_RD_HOLD, 16'h0001, 16'h0, 16'h3412, 1'b0);
    rw(OP_WR_HOLD, 16'h0066, 16'h2211, 16'h2211, 1'b0);
    check(maximum_start_time, 16'h1122);
    word_order = 1'b0;
  endtask : s_direct
  task automatic s_mapped;
    boot(MODE_MAPPED, REACT_ALARM, 10'h0);
    rw(OP_RD_HOLD, 16'h0100, 16'h0, 16'h1234, 1'b0);
    rw(OP_RD_HOLD, 16'h0101, 16'h0, 16'hA5C3, 1'b0);
    rw(OP_RD_HOLD, 16'h0102, 16'h0, 16'h0, 1'b0);
    rw(OP_RD_INPUT, 16'h0001, 16'h0, 16'hA5C3, 1'b0);
    rw(OP_WR_HOLD, 16'h0000, 16'h4321, 16'h4321, 1'b0);
    rw(OP_WR_HOLD, 16'h0001, 16'h00F0, 16'h00F0, 1'b0);
    check(fieldbus_control_word, 16'h00F0);
    rw(OP_WR_HOLD, 16'h0100, 16'h5555, 16'h5555, 1'b0);
    check(initial_start_voltage, 16'h4321);
    rw(OP_RD_HOLD, 16'h04B7, 16'h0, 16'hA5C3, 1'b0);
    rw(OP_RD_HOLD, 16'h0210, 16'h0, 16'h1234, 1'b0);
    rw(OP_RD_HOLD, 16'h0205, 16'h0, 16'h0, 1'b0);
    rw(OP_RD_COIL, 16'h0014, 16'h0, 16'h0001, 1'b0);
    rw(OP_RD_COIL, 16'h0013, 16'h0, 16'h0, 1'b0);
    rw(OP_WR_COIL, 16'h0000, 16'h0, 16'h0, 1'b0);
    check(initial_start_voltage, 16'h4320);
    rw(OP_RD_DISC, 16'h0004, 16'h0, 16'h0001, 1'b0);
    rw(OP_RD_DISC, 16'h0013, 16'h0, 16'h0, 1'b0);
    address_compat_mode = MODE_DIRECT;
    rw(OP_RD_HOLD, 16'h0100, 16'h0, 16'h1234, 1'b0);
    boot(MODE_DIRECT, REACT_ALARM, 10'h0);
    rw(OP_RD_HOLD, 16'h0001, 16'h0, 16'h1234, 1'b0);
  endtask : s_mapped
  task automatic s_offline;
    boot(MODE_DIRECT, REACT_ALARM, 10'd3);
    link_down = 1'b1;
    cyc(3);
    check(16'(offline_alarm), 16'h0001);
    check(16'(offline_fault), 16'h0);
    link_down = 1'b0;
    cyc(3);
    check(16'(offline_alarm), 16'h0);
    rw(OP_RD_HOLD, 16'h0001, 16'h0, 16'h1234, 1'b0);
    cyc(40);
    check(16'(offline_state), 16'h0001);
    rw(OP_RD_HOLD, 16'h0001, 16'h0, 16'h1234, 1'b0);
    cyc(3);
    check(16'(offline_alarm), 16'h0);
    boot(MODE_DIRECT, REACT_ALARM, 10'h0);
    rw(OP_RD_HOLD, 16'h0001, 16'h0, 16'h1234, 1'b0);
    cyc(40);
    check(16'(offline_state), 16'h0);
    boot(MODE_DIRECT, 1'b1, 10'h0);
    link_down = 1'b1;
    cyc(2);
    link_down = 1'b0;
    cyc(3);
    check(16'(offline_fault), 16'h0001);
  endtask : s_offline
  task automatic s_access;
    boot(MODE_DIRECT, REACT_ALARM, 10'h0);
    module_read_fail = 1'b1;
    cyc(1);
    module_read_fail = 1'b0;
    cyc(2);
    check(16'(module_access_alarm), 16'h0001);
    cyc(5);
    check(16'({module_access_alarm, req_ready}), 16'h0002);
    boot(MODE_DIRECT, REACT_ALARM, 10'h0);
    module_hw_incompat = 1'b1;
    cyc(2);
    check(16'(module_access_alarm), 16'h0001);
    boot(MODE_DIRECT, 1'b1, 10'h0);
    native_board_fitted = 1'b1;
    cyc(2);
    check(16'({module_access_fault, module_enabled}), 16'h0002);
  endtask : s_access
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {address_compat_mode, word_order, error_reaction_setting} = 3'h0;
    tcp_inactivity_timeout = 10'h0;
    first_word_map_selector = {66'h0, 11'h2A8, 11'h001};
    last_word_map_selector = {66'h0, 11'h2AE, 11'h065};
    drive_access_code = 16'h0007;
    starter_current = 16'h1234;
    motor_current_percent = 16'h0042;
    starter_status_word = 16'hA5C3;
    {link_down, module_read_fail, module_hw_incompat, native_board_fitted} = 4'h0;
    s_direct;
    s_mapped;
    s_offline;
    s_access;
    complete_run;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    complete_run;
  end
endmodule : testbench
